// ===== nvc_pkg.sv
// Shared constants and carriers for the nonvolatile SRAM pin controller.
// Assumes a 20 MHz core clock; the memory itself is asynchronous.
package nvc_pkg;
  // ------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int DEPTH = 2048;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int INIT_HOLD_NS = 25;
  localparam int RECALL_MAX_US = 20;
  localparam int STORE_MAX_MS = 10;
  localparam int ACCESS_NS = 45;
  localparam int SETUP_NS = 5;
  // Least times round up, at least one cycle
  localparam int INIT_HOLD_CYC =
    (INIT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC =
    (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int RECALL_CYC = RECALL_MAX_US * 1000 / CLK_PERIOD_NS;
  localparam int STORE_CYC = STORE_MAX_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [3:0] PINS_IDLE = 4'hf;
  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    CMD_READ = 2'b00,
    CMD_WRITE = 2'b01,
    CMD_STORE = 2'b10,
    CMD_RECALL = 2'b11
  } cmd_e;
  typedef struct packed {
    cmd_e cmd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } req_s;
  // Active-low control pins towards the memory
  typedef struct packed {
    logic chip_sel_n;
    logic out_en_n;
    logic wr_en_n;
    logic shadow_transfer_n;
  } ctl_s;
endpackage

// ===== nvc_wait.sv
// Down counter that times one phase of a pin sequence.
// Assumes load and the count come from the same clock domain.
module nvc_wait #(
  parameter int CNT_W = 18
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Control
  input wire logic load,
  input wire logic [CNT_W-1:0] count,
  // Status
  output logic done
);
  logic [CNT_W-1:0] cnt_r;

  if (CNT_W < 1)
  begin : g_bad_width
    $error("nvc_wait: counter width must be at least one");
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      cnt_r <= '0;
    else if (load)
      cnt_r <= count;
    else if (cnt_r != '0)
      cnt_r <= cnt_r - 1'b1;
  end

  // Done reads the count only: the caller's load is built from it
  assign done = (cnt_r == '0);
endmodule

// ===== nvc_host.sv
// Host-side controller that drives a 2K x 8 nonvolatile SRAM by its pins.
// Assumes the memory answers asynchronously; read data is synchronised.
// Store and recall end only by the memory's own timing, so the controller
// waits the documented worst case before it touches the pins again.
import nvc_pkg::*;

// Summary of operation
// - Hold recall pin state at least 25 ns
// - Any of four pins ends store initiation
// - Shadow, select or output enable ends recall
// - Keep other pins static during select store
module nvc_host #(
  parameter int RECALL_WAIT = RECALL_CYC,
  parameter int STORE_WAIT = STORE_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Request side
  input wire nvc_pkg::req_s req,
  input wire logic req_valid,
  output logic req_ready,
  output logic [nvc_pkg::DATA_W-1:0] rd_data,
  output logic rd_valid,
  // Memory pins
  output nvc_pkg::ctl_s ctl,
  output logic [nvc_pkg::ADDR_W-1:0] word_select_bus,
  output logic [nvc_pkg::DATA_W-1:0] byte_bus_o,
  output logic byte_bus_oe_n,
  input wire logic [nvc_pkg::DATA_W-1:0] byte_bus_i
);
  import nvc_pkg::*;

  localparam int CNT_W = 18;

  if (RECALL_WAIT < 1 || STORE_WAIT < 1 ||
      RECALL_WAIT >= (1 << CNT_W) || STORE_WAIT >= (1 << CNT_W))
  begin : g_bad_wait
    $error("nvc_host: wait counts out of range");
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_HOLD = 3'b010,
    ST_XFER = 3'b011,
    ST_READ = 3'b100,
    ST_GAP = 3'b101
  } state_e;

  state_e state_r;
  req_s cur_r;
  logic [DATA_W-1:0] sync1_r;
  logic [DATA_W-1:0] sync2_r;
  logic wait_load;
  logic [CNT_W-1:0] wait_count;
  logic wait_done;

  // Final active-low pin pattern for each command
  function automatic ctl_s pins_of(cmd_e c);
    ctl_s p;
    p = PINS_IDLE;
    unique case (c)
      CMD_READ:
        p = '{chip_sel_n: 1'b0, out_en_n: 1'b0, wr_en_n: 1'b1,
              shadow_transfer_n: 1'b1};
      CMD_WRITE:
        p = '{chip_sel_n: 1'b0, out_en_n: 1'b1, wr_en_n: 1'b0,
              shadow_transfer_n: 1'b1};
      CMD_STORE:
        p = '{chip_sel_n: 1'b0, out_en_n: 1'b1, wr_en_n: 1'b0,
              shadow_transfer_n: 1'b0};
      CMD_RECALL:
        p = '{chip_sel_n: 1'b0, out_en_n: 1'b0, wr_en_n: 1'b1,
              shadow_transfer_n: 1'b0};
    endcase
    return p;
  endfunction

  // Setup pattern: select withheld so it is the last edge in.
  // Store is select-controlled: write enable is already low, so
  // the recall combination never appears on the way in.
  function automatic ctl_s setup_of(cmd_e c);
    ctl_s p;
    p = pins_of(c);
    p.chip_sel_n = 1'b1;
    return p;
  endfunction

  nvc_wait #(.CNT_W(CNT_W)) u_wait (
    .core_clk(core_clk),
    .rstn(rstn),
    .load(wait_load),
    .count(wait_count),
    .done(wait_done)
  );

  always_comb
  begin
    wait_load = 1'b0;
    wait_count = '0;
    unique case (state_r)
      ST_IDLE:
      begin
        wait_load = req_valid;
        wait_count = CNT_W'(SETUP_CYC);
      end
      ST_SETUP:
      begin
        wait_load = wait_done;
        wait_count = (cur_r.cmd == CMD_READ) ? CNT_W'(ACCESS_CYC)
                                              : CNT_W'(INIT_HOLD_CYC);
      end
      ST_HOLD:
      begin
        wait_load = wait_done;
        wait_count = (cur_r.cmd == CMD_STORE) ? CNT_W'(STORE_WAIT)
                   : (cur_r.cmd == CMD_RECALL) ? CNT_W'(RECALL_WAIT)
                   : CNT_W'(SETUP_CYC);
      end
      default:
        ;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      state_r <= ST_IDLE;
    else
    begin
      unique case (state_r)
        ST_IDLE:
          if (req_valid)
            state_r <= ST_SETUP;
        ST_SETUP:
          if (wait_done)
            state_r <= (cur_r.cmd == CMD_READ) ? ST_READ : ST_HOLD;
        ST_HOLD:
          if (wait_done)
            state_r <= (cur_r.cmd inside {CMD_STORE, CMD_RECALL})
                       ? ST_XFER : ST_GAP;
        ST_READ:
          if (wait_done)
            state_r <= ST_GAP;
        ST_XFER:
          if (wait_done)
            state_r <= ST_IDLE;
        ST_GAP:
          state_r <= ST_IDLE;
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      cur_r <= '0;
    else if (state_r == ST_IDLE && req_valid)
      cur_r <= req;
  end

  // ------------------------------------------------------------
  // Pins
  // ------------------------------------------------------------
  // Leaving to all-high each time gives a fresh edge into the
  // transfer state, so a held pattern never retriggers.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      ctl <= PINS_IDLE;
    else if (state_r == ST_IDLE && req_valid)
      ctl <= setup_of(req.cmd);
    else if (state_r == ST_SETUP && wait_done)
      ctl <= pins_of(cur_r.cmd);
    else if ((state_r == ST_HOLD || state_r == ST_READ) && wait_done)
      ctl <= PINS_IDLE;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      word_select_bus <= '0;
      byte_bus_o <= '0;
    end
    else if (state_r == ST_IDLE && req_valid)
    begin
      word_select_bus <= req.addr;
      byte_bus_o <= req.wdata;
    end
  end

  // Driven only for writes; floated through store and recall
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      byte_bus_oe_n <= 1'b1;
    else if (state_r == ST_IDLE && req_valid)
      byte_bus_oe_n <= (req.cmd != CMD_WRITE);
    else if (state_r == ST_HOLD && wait_done)
      byte_bus_oe_n <= 1'b1;
  end

  // ------------------------------------------------------------
  // Read return
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r <= byte_bus_i;
      sync2_r <= sync1_r;
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_data <= '0;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_valid <= (state_r == ST_READ) && wait_done;
      if ((state_r == ST_READ) && wait_done)
        rd_data <= sync2_r;
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      req_ready <= 1'b0;
    else
      req_ready <= (state_r == ST_GAP) ||
                   (state_r == ST_XFER && wait_done) ||
                   (state_r == ST_IDLE && !req_valid);
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  chk_store_pins_held: assert property (@(posedge core_clk) disable iff (!rstn)
    (state_r == ST_HOLD && cur_r.cmd == CMD_STORE) |->
      ctl == pins_of(CMD_STORE))
    else $error("store pins moved during initiation");
  chk_recall_min_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    $fell(ctl.chip_sel_n) && !ctl.shadow_transfer_n && ctl.wr_en_n |->
      !ctl.chip_sel_n [*2])
    else $error("recall state held too briefly");
  chk_xfer_bus_float: assert property (@(posedge core_clk) disable iff (!rstn)
    state_r == ST_XFER |-> byte_bus_oe_n && ctl == PINS_IDLE)
    else $error("pins active during transfer");
  chk_no_recall_combo: assert property (@(posedge core_clk) disable iff (!rstn)
    cur_r.cmd == CMD_STORE && state_r != ST_IDLE |->
      !(!ctl.chip_sel_n && ctl.wr_en_n && !ctl.out_en_n))
    else $error("recall pattern while storing");
  chk_recall_time: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(state_r == ST_XFER) && cur_r.cmd == CMD_RECALL |->
      ##[1:450] state_r == ST_IDLE)
    else $error("recall wait not ended");
  chk_read_valid: assert property (@(posedge core_clk) disable iff (!rstn)
    rd_valid |-> $past(state_r == ST_READ) && ctl == PINS_IDLE)
    else $error("read data returned outside read");
  chk_fresh_edge: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(state_r == ST_XFER) |-> ctl == PINS_IDLE)
    else $error("transfer state held after initiation");
  chk_write_drive: assert property (@(posedge core_clk) disable iff (!rstn)
    !byte_bus_oe_n |-> cur_r.cmd == CMD_WRITE && ctl.shadow_transfer_n)
    else $error("bus driven outside write");

  cov_store: cover property (@(posedge core_clk) disable iff (!rstn)
    state_r == ST_XFER && cur_r.cmd == CMD_STORE);
  cov_recall: cover property (@(posedge core_clk) disable iff (!rstn)
    state_r == ST_XFER && cur_r.cmd == CMD_RECALL);
  cov_read: cover property (@(posedge core_clk) disable iff (!rstn)
    rd_valid);
endmodule

// ===== nvsram_model.sv
// Behavioural model of the 2K x 8 nonvolatile SRAM facing the controller.
// Assumes the bench resolves the shared byte bus and feeds it back here.
module nvsram_model #(
  parameter int STORE_NS = 300,
  parameter int RECALL_NS = 150
) (
  // Pins from the host
  input wire nvc_pkg::ctl_s ctl,
  input wire logic [nvc_pkg::ADDR_W-1:0] word_select_bus,
  input wire logic [nvc_pkg::DATA_W-1:0] bus_in,
  // Supply sense, high while the supply is below its trip level
  input wire logic supply_low,
  // Data driven by the memory
  output logic [nvc_pkg::DATA_W-1:0] dq,
  // Activity seen
  output int n_store,
  output int n_recall,
  output int n_bad
);
  timeunit 1ns;
  timeprecision 100ps;
  import nvc_pkg::*;
  logic [DATA_W-1:0] mem [DEPTH];
  logic [DATA_W-1:0] shadow [DEPTH];
  logic [DATA_W-1:0] last = 8'h00;
  logic busy = 1'b0;
  ctl_s pc = PINS_IDLE;
  int st;
  int prev = 0;
  realtime t_in = 0;
  wire [DATA_W-1:0] bus_d;
  wire [ADDR_W-1:0] sel_d;
  // Delayed copies: a write closes on values held just before the edge
  assign #1 bus_d = bus_in;
  assign #1 sel_d = word_select_bus;
  initial
  begin
    mem = '{default: 8'h00};
    shadow = '{default: 8'h00};
    n_store = 0;
    n_recall = 0;
    n_bad = 0;
  end
  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  always @*
  begin
    if (!busy && !ctl.chip_sel_n && !ctl.out_en_n && ctl.wr_en_n &&
        ctl.shadow_transfer_n)
    begin
      dq = mem[word_select_bus];
      last = dq;
    end
    else
      dq = ~last;
  end
  // ------------------------------------------------------------
  // Pin decode, writes and transfer triggers
  // ------------------------------------------------------------
  always @(ctl)
  begin
    st = 0;
    if (!ctl.chip_sel_n && !ctl.shadow_transfer_n && ctl.out_en_n &&
        !ctl.wr_en_n)
      st = 1;
    else if (!ctl.chip_sel_n && !ctl.shadow_transfer_n && !ctl.out_en_n &&
             ctl.wr_en_n)
      st = 2;
    if (prev != 0 && st != prev && $realtime - t_in < 25.0)
      n_bad++;
    if (!busy && !pc.chip_sel_n && !pc.wr_en_n && pc.shadow_transfer_n &&
        (ctl.chip_sel_n || ctl.wr_en_n))
      mem[sel_d] = bus_d;
    if (st != prev)
      t_in = $realtime;
    // Only a fresh entry triggers, so a held state never repeats
    if (!busy && st != 0 && st != prev && !(st == 1 && supply_low))
    begin
      busy = 1'b1;
      fork
        transfer(st);
      join_none
    end
    prev = st;
    pc = ctl;
  end
  task automatic transfer(int kind);
    if (kind == 1)
    begin
      n_store++;
      shadow = '{default: 8'h00};
      #(STORE_NS);
      // Low supply abandons the copy; the shadow stays erased
      if (!supply_low)
        shadow = mem;
    end
    else
    begin
      n_recall++;
      mem = '{default: 8'h00};
      #(RECALL_NS);
      mem = shadow;
    end
    busy = 1'b0;
  endtask
endmodule

// ===== nvsram_store_recall_control_bench.sv
// Self-checking bench: controller against the memory model.
// Assumes short transfer waits on the controller and a 50 ns clock.
`define CHK(nm, e, g) \
  begin \
    n_compared++; \
    if ((g) !== (e)) \
    begin \
      errors++; \
      $display("unexpected %s exp %h got %h", nm, e, g); \
    end \
  end
module nvsram_store_recall_control_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import nvc_pkg::*;
  logic core_clk;
  logic rstn;
  req_s req;
  logic req_valid;
  logic req_ready;
  logic [DATA_W-1:0] rd_data;
  logic rd_valid;
  ctl_s ctl;
  logic [ADDR_W-1:0] word_select_bus;
  logic [DATA_W-1:0] byte_bus_o;
  logic byte_bus_oe_n;
  logic [DATA_W-1:0] dq;
  wire [DATA_W-1:0] bus;
  logic supply_low;
  int n_store;
  int n_recall;
  int n_bad;
  int errors;
  int n_compared;
  logic [DATA_W-1:0] ram [DEPTH];
  logic [DATA_W-1:0] nvm [DEPTH];
  int used[$];
  assign bus = !byte_bus_oe_n ? byte_bus_o : dq;
  nvc_host #(.RECALL_WAIT(4), .STORE_WAIT(8)) nvc_host_i (
    .core_clk(core_clk), .rstn(rstn), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid),
    .ctl(ctl), .word_select_bus(word_select_bus), .byte_bus_o(byte_bus_o),
    .byte_bus_oe_n(byte_bus_oe_n), .byte_bus_i(bus));
  nvsram_model nvsram_model_i (
    .ctl(ctl), .word_select_bus(word_select_bus), .bus_in(bus), .dq(dq),
    .supply_low(supply_low),
    .n_store(n_store), .n_recall(n_recall), .n_bad(n_bad));
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic stop_test();
    if (errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  function automatic logic [ADDR_W-1:0] pick(int i);
    if (i == 0)
      return '0;
    if (i == 1)
      return ADDR_W'(DEPTH - 1);
    return ADDR_W'($urandom_range(DEPTH - 1));
  endfunction
  task automatic op(cmd_e c, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d,
                    output logic [DATA_W-1:0] q, output logic got);
    int n;
    n = 0;
    got = 1'b0;
    q = 8'h00;
    @(posedge core_clk);
    req <= '{cmd: c, addr: a, wdata: d};
    req_valid <= 1'b1;
    do
    begin
      @(negedge core_clk);
      n++;
    end
    while (req_ready !== 1'b1 && n < 100);
    @(posedge core_clk);
    req_valid <= 1'b0;
    do
    begin
      @(negedge core_clk);
      n++;
      if (rd_valid === 1'b1)
      begin
        got = 1'b1;
        q = rd_data;
      end
    end
    while (req_ready !== 1'b1 && n < 200);
    if (req_ready !== 1'b1)
    begin
      errors++;
      stop_test();
    end
  endtask
  task automatic read_all();
    logic [DATA_W-1:0] q;
    logic got;
    foreach (used[k])
    begin
      op(CMD_READ, ADDR_W'(used[k]), 8'h00, q, got);
      `CHK("rd_valid", 1'b1, got)
      `CHK("rd_data", ram[used[k]], q)
    end
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
    logic [DATA_W-1:0] q;
    logic got;
    rstn = 1'b0;
    req = '0;
    req_valid = 1'b0;
    supply_low = 1'b0;
    errors = 0;
    n_compared = 0;
    ram = '{default: 8'h00};
    nvm = '{default: 8'h00};
    void'($urandom(98695));
    repeat (6) @(negedge core_clk);
    `CHK("ctl in reset", PINS_IDLE, ctl)
    `CHK("oe_n in reset", 1'b1, byte_bus_oe_n)
    @(posedge core_clk);
    rstn <= 1'b1;
    for (int r = 0; r < 2; r++)
    begin
      for (int i = 0; i < 24; i++)
      begin
        a = (i < 2) ? pick(i) : pick(2);
        d = 8'($urandom);
        op(CMD_WRITE, a, d, q, got);
        ram[a] = d;
        used.push_back(int'(a));
      end
      read_all();
      op(CMD_STORE, '0, 8'h00, q, got);
      nvm = ram;
      // Overwrite after the store so the recall has something to undo
      for (int i = 0; i < 8; i++)
      begin
        a = ADDR_W'(used[$urandom_range(used.size() - 1)]);
        d = ~ram[a];
        op(CMD_WRITE, a, d, q, got);
        ram[a] = d;
      end
      read_all();
      op(CMD_RECALL, '0, 8'h00, q, got);
      ram = nvm;
      read_all();
    end
    // Low supply must refuse the store, so recall brings the old copy
    a = ADDR_W'(used[0]);
    d = ~ram[a];
    supply_low = 1'b1;
    op(CMD_WRITE, a, d, q, got);
    op(CMD_STORE, '0, 8'h00, q, got);
    supply_low = 1'b0;
    `CHK("refused store", 2, n_store)
    op(CMD_RECALL, '0, 8'h00, q, got);
    ram = nvm;
    read_all();
    `CHK("stores", 2, n_store)
    `CHK("recalls", 3, n_recall)
    `CHK("short holds", 0, n_bad)
    stop_test();
  end
endmodule
